// ==== hdl/tlic_map.vh ====
// constants for the two-level interrupt controller
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH

// =====================================================================
// register offsets (byte addresses)
`define TLIC_OFF_CTRL 12'h000
`define TLIC_OFF_MODE 12'h004
`define TLIC_OFF_FLAG 12'h008
`define TLIC_OFF_ENABLE 12'h00c
`define TLIC_OFF_PRIO 12'h010
`define TLIC_OFF_STATUS 12'h014
`define TLIC_OFF_EVENT 12'h018

// =====================================================================
// control and mode register bit positions
`define TLIC_BIT_GIE 7
`define TLIC_BIT_PERIPHERAL_GROUP_ENABLE 6
`define TLIC_BIT_PRIORITY_MODE_ENABLE 7

// =====================================================================
// vectors and reset values
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_CTRL_RST 8'h00
`define TLIC_MODE_RST 8'h00

// =====================================================================
// timing: instruction-cycle length and latency window
`define TLIC_CYC_PER_INSTR 4
`define TLIC_LAT_MIN 3
`define TLIC_LAT_MAX 4

`endif

// ==== hdl/tlic_flags.v ====
// per-source sticky flags with software write-one-to-clear
`timescale 1ns/1ps
`include "tlic_map.vh"

module tlic_flags #(
  parameter N = 8
) (
  input wire pclk,
  input wire presetn,
  input wire [N-1:0] event_in,
  input wire [N-1:0] clear_mask,
  output reg [N-1:0] flag
);

  // =====================================================================
  // flags: set always wins over clear
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag[i] <= 1'b0;
        end else if (event_in[i]) begin
          flag[i] <= 1'b1;
        end else if (clear_mask[i]) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // tlic_flags

// ==== hdl/tlic_cycle.v ====
// instruction-cycle phase counter for the controller
`timescale 1ns/1ps
`include "tlic_map.vh"

module tlic_cycle #(
  parameter CYC = `TLIC_CYC_PER_INSTR
) (
  input wire pclk,
  input wire presetn,
  output reg cycle_end
);

  // =====================================================================
  // one pulse at the end of each instruction cycle
  reg [7:0] cnt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      cycle_end <= 1'b0;
    end else begin
      if (cnt == CYC[7:0] - 8'h01) begin
        cnt <= 8'h00;
        cycle_end <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
        cycle_end <= 1'b0;
      end
    end
  end

endmodule // tlic_cycle

// ==== hdl/tlic_top.v ====
// two-level prioritized interrupt controller with apb registers
// Functional notes
// - high priority vectors to 0008h, low priority vectors to 0018h
// - high request preempts a running low routine in priority mode
// - each source has flag, enable and priority controls
// - priority operation only while priority_mode_enable is set
// - priority mode: bit 7 gates high sources, bit 6 gates low sources
// - flag, enable and group enable all set vectors at once by priority
// - priority mode clear at reset; priority bits then ignored
// - compatibility: bit 6 gates peripherals, bit 7 gates all sources
// - compatibility mode: every interrupt vectors to 0008h
// - acceptance clears the governing global or group enable
// - low requests not serviced during a high routine
// - core pushes return address and loads vector on acceptance
// - return instruction exits routine and sets governing enable again
// - external and port-change latency three to four instruction cycles
// - flags set on event regardless of enables
// - cleared individual enable blocks vectoring even with flag set
// - priority mode: bit 6 acts as low group enable
// - flags stay set until software clears them
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tlic_map.vh"

module tlic_top #(
  parameter N = 8,
  parameter [N-1:0] PERIPH_MASK = 8'hf8,
  parameter CYC = `TLIC_CYC_PER_INSTR
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [N-1:0] irq_event,
  input wire vec_ack,
  input wire irq_return_instr,
  output reg vec_req,
  output reg [15:0] vec_addr,
  output wire in_high_isr,
  output wire in_low_isr
);

  // =====================================================================
  // states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_REQ = 3'b100;

  // =====================================================================
  // registers
  reg global_irq_enable;
  reg peripheral_group_enable;
  reg priority_mode_enable;
  reg [N-1:0] src_enable;
  reg [N-1:0] src_prio;
  reg high_active;
  reg low_active;
  reg req_high;
  reg [2:0] state;
  reg [2:0] wait_cnt;
  wire [N-1:0] flag;
  wire cycle_end;
  reg [N-1:0] clear_mask;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  wire addr_ok = (paddr == `TLIC_OFF_CTRL) | (paddr == `TLIC_OFF_MODE) |
    (paddr == `TLIC_OFF_FLAG) | (paddr == `TLIC_OFF_ENABLE) |
    (paddr == `TLIC_OFF_PRIO) | (paddr == `TLIC_OFF_STATUS) |
    (paddr == `TLIC_OFF_EVENT);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign in_high_isr = high_active;
  assign in_low_isr = low_active;

  // =====================================================================
  // sub-blocks
  tlic_flags #(.N(N)) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(irq_event),
    .clear_mask(clear_mask),
    .flag(flag)
  );

  tlic_cycle #(.CYC(CYC)) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .cycle_end(cycle_end)
  );

  // =====================================================================
  // request qualification
  wire [N-1:0] pend = flag & src_enable;
  wire [N-1:0] hi_src = priority_mode_enable ? src_prio : {N{1'b1}};
  wire [N-1:0] lo_src = ~src_prio;
  wire any_high_pri = |(pend & hi_src);
  wire any_low_pri = |(pend & lo_src);
  wire compat_any = |(pend & ~PERIPH_MASK) |
    (peripheral_group_enable & |(pend & PERIPH_MASK));
  // priority mode: high group gated by bit 7, low group by bit 6
  wire elig_high = priority_mode_enable ?
    (global_irq_enable & any_high_pri) :
    (global_irq_enable & compat_any);
  wire elig_low = priority_mode_enable & peripheral_group_enable &
    any_low_pri & ~high_active;
  wire high_ok = elig_high & ~high_active & (~priority_mode_enable | 1'b1);
  wire take_high = high_ok;
  wire take_any = take_high | (elig_low & ~low_active);

  // =====================================================================
  // sequencer: sample per instruction cycle, one request at a time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      wait_cnt <= 3'h0;
      req_high <= 1'b0;
      vec_req <= 1'b0;
      vec_addr <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cycle_end & take_any) begin
            req_high <= take_high;
            wait_cnt <= 3'h0;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cycle_end) begin
            if (wait_cnt == `TLIC_LAT_MIN - 2) begin
              vec_req <= 1'b1;
              if (req_high | ~priority_mode_enable) begin
                vec_addr <= `TLIC_VEC_HIGH;
              end else begin
                vec_addr <= `TLIC_VEC_LOW;
              end
              state <= ST_REQ;
            end else begin
              wait_cnt <= wait_cnt + 3'h1;
            end
          end
        end
        ST_REQ: begin
          if (vec_ack) begin
            vec_req <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  wire accept = (state == ST_REQ) & vec_ack;

  // =====================================================================
  // control, enables and routine tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
      peripheral_group_enable <= 1'b0;
      priority_mode_enable <= 1'b0;
      src_enable <= {N{1'b0}};
      src_prio <= {N{1'b1}};
      high_active <= 1'b0;
      low_active <= 1'b0;
    end else begin
      if (wr_en & (paddr == `TLIC_OFF_CTRL)) begin
        global_irq_enable <= pwdata[`TLIC_BIT_GIE];
        peripheral_group_enable <= pwdata[`TLIC_BIT_PERIPHERAL_GROUP_ENABLE];
      end
      if (wr_en & (paddr == `TLIC_OFF_MODE)) begin
        priority_mode_enable <= pwdata[`TLIC_BIT_PRIORITY_MODE_ENABLE];
      end
      if (wr_en & (paddr == `TLIC_OFF_ENABLE)) begin
        src_enable <= pwdata[N-1:0];
      end
      if (wr_en & (paddr == `TLIC_OFF_PRIO)) begin
        src_prio <= pwdata[N-1:0];
      end
      if (accept) begin
        if (req_high | ~priority_mode_enable) begin
          global_irq_enable <= 1'b0;
          high_active <= 1'b1;
        end else begin
          peripheral_group_enable <= 1'b0;
          low_active <= 1'b1;
        end
      end else if (irq_return_instr) begin
        if (high_active) begin
          global_irq_enable <= 1'b1;
          high_active <= 1'b0;
        end else if (low_active) begin
          if (priority_mode_enable) begin
            peripheral_group_enable <= 1'b1;
          end else begin
            global_irq_enable <= 1'b1;
          end
          low_active <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // flag clearing and read data
  always @* begin
    clear_mask = {N{1'b0}};
    if (wr_en & (paddr == `TLIC_OFF_FLAG)) begin
      clear_mask = pwdata[N-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `TLIC_OFF_CTRL: prdata <= {24'h000000, global_irq_enable, peripheral_group_enable,
          6'h00};
        `TLIC_OFF_MODE: prdata <= {24'h000000, priority_mode_enable, 7'h00};
        `TLIC_OFF_FLAG: prdata <= {{(32-N){1'b0}}, flag};
        `TLIC_OFF_ENABLE: prdata <= {{(32-N){1'b0}}, src_enable};
        `TLIC_OFF_PRIO: prdata <= {{(32-N){1'b0}}, src_prio};
        `TLIC_OFF_STATUS: prdata <= {28'h0000000, vec_req, req_high, high_active,
          low_active};
        `TLIC_OFF_EVENT: prdata <= {{(32-N){1'b0}}, pend};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // tlic_top

// ==== test/tlic_core_model.sv ====
// core sequencer model answering vector requests
`timescale 1ns/1ps
module tlic_core_model (
  input wire pclk,
  input wire presetn,
  input wire vec_req,
  input wire slow,
  input wire do_ret,
  output reg vec_ack,
  output reg irq_return_instr
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ack <= 1'b0;
      irq_return_instr <= 1'b0;
    end else begin
      vec_ack <= vec_req && !vec_ack && !slow;
      irq_return_instr <= do_ret;
    end
  end
endmodule // tlic_core_model

// ==== test/tlic_monitor.sv ====
// assertion checker for the interrupt controller ports
`timescale 1ns/1ps
module tlic_monitor (
  input wire pclk,
  input wire presetn,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire vec_ack,
  input wire vec_req,
  input wire [15:0] vec_addr,
  input wire in_high_isr,
  input wire in_low_isr
);
  reg mode;
  wire acc = vec_req && vec_ack;
  wire hi = vec_addr == 16'h0008;
  always @(posedge pclk or negedge presetn)
    if (!presetn) mode <= 1'b0;
    else if (penable && pwrite && paddr == 12'h004) mode <= pwdata[7];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_VEC: assert property (vec_req |-> hi || vec_addr == 16'h0018)
    else $error("bad vector");
  AST_CMP: assert property (vec_req && !mode |-> hi) else $error("compat vector");
  AST_NOLO: assert property (!mode |-> !in_low_isr) else $error("low in compat");
  AST_BLK: assert property (in_high_isr && vec_req |-> hi) else $error("low in high");
  AST_HOLD: assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_addr))
    else $error("request dropped");
  AST_ONE: assert property (acc |=> !vec_req) else $error("request after ack");
  AST_ENH: assert property (acc && hi |=> in_high_isr) else $error("no high entry");
  AST_ENL: assert property (acc && !hi |=> in_low_isr) else $error("no low entry");
  AST_PRE: assert property (in_low_isr && acc && hi |=> in_low_isr && in_high_isr)
    else $error("preempt lost");
  cover property (acc && !hi);
  cover property (in_low_isr && in_high_isr);
  cover property (acc && !mode);
endmodule // tlic_monitor
bind tlic_top tlic_monitor mon (.pclk(pclk), .presetn(presetn), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .vec_ack(vec_ack), .vec_req(vec_req),
  .vec_addr(vec_addr), .in_high_isr(in_high_isr), .in_low_isr(in_low_isr));

// ==== test/tlic_top_test.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tlic_top_test;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg do_ret = 1'b0, slow = 1'b0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [7:0] irq_event = 8'h00;
  reg [3:0] rn;
  reg [15:0] expq[$];
  wire [31:0] prdata;
  wire [15:0] vec_addr;
  wire pready, pslverr, vec_ack, irq_return_instr, vec_req, in_high_isr, in_low_isr;
  integer seed = 32'h232f8ec5, errors = 0, comparisons = 0, accepted = 0, lat, k, t;
  always #10 pclk = ~pclk;
  always @(posedge pclk) slow <= 1'($random(seed));
  tlic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_event(irq_event), .vec_ack(vec_ack),
    .irq_return_instr(irq_return_instr), .vec_req(vec_req), .vec_addr(vec_addr),
    .in_high_isr(in_high_isr), .in_low_isr(in_low_isr));
  tlic_core_model core (.pclk(pclk), .presetn(presetn), .vec_req(vec_req), .slow(slow),
    .do_ret(do_ret), .vec_ack(vec_ack), .irq_return_instr(irq_return_instr));
  task chk(input string n, input [31:0] e, input [31:0] s);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("BAD %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  always @(posedge pclk) begin
    if (vec_req === 1'b1 && vec_ack === 1'b1) begin
      accepted <= accepted + 1;
      chk("vec_addr", expq.size() ? expq.pop_front() : 16'hffff, vec_addr);
    end
  end
  task results;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d); // single bus read or write; read data checked against d
    begin
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (t = 0; t < 9 && pready !== 1'b1; t = t + 1) @(posedge pclk);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      chk("pready", 1, pready);
      if (pready !== 1'b1) results;
      if (!wr) chk($sformatf("reg %h", a), d, rd);
    end
  endtask
  task pulse(input [8:0] m);
    begin
      @(posedge pclk);
      {do_ret, irq_event} <= m;
      @(posedge pclk);
      {do_ret, irq_event} <= 9'h000;
      repeat (3) @(posedge pclk);
    end
  endtask
  task wait_acc(input integer n);
    begin
      lat = 0;
      for (t = 0; t < 99 && accepted != n; t = t + 1) begin
        lat = lat + (vec_req !== 1'b1);
        @(posedge pclk);
      end
      chk("accepted", n, accepted);
      if (accepted != n) results;
    end
  endtask
  task quiet;
    begin
      k = accepted;
      repeat (40) @(posedge pclk);
      chk("accepted", k, accepted);
    end
  endtask
  // ==========================================
  // stimulus
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h010, 32'hff);
    apb(0, 12'h004, 32'h00);
    apb(0, 12'hffc, 32'h00);
    chk("slverr", 1, err);
    apb(1, 12'h00c, 32'h09);
    apb(1, 12'h000, 32'h80);
    rn = 4'($random(seed));
    pulse({1'b0, rn, 4'h2});
    quiet;
    apb(0, 12'h008, {24'h000000, rn, 4'h2});
    apb(1, 12'h008, 32'hf2);
    pulse(9'h008);
    quiet;
    expq.push_back(16'h0008);
    pulse(9'h001);
    wait_acc(1);
    chk("latency", 1, lat <= 12);
    apb(0, 12'h000, 32'h00);
    apb(0, 12'h008, 32'h09);
    apb(1, 12'h008, 32'h01);
    pulse(9'h100);
    apb(0, 12'h000, 32'h80);
    expq.push_back(16'h0008);
    apb(1, 12'h000, 32'hc0);
    wait_acc(2);
    apb(1, 12'h008, 32'h08);
    pulse(9'h100);
    apb(1, 12'h010, 32'hf7);
    apb(1, 12'h004, 32'h80);
    expq.push_back(16'h0018);
    pulse(9'h008);
    wait_acc(3);
    expq.push_back(16'h0008);
    pulse(9'h001);
    wait_acc(4);
    apb(0, 12'h000, 32'h00);
    apb(1, 12'h008, 32'h09);
    pulse(9'h100);
    pulse(9'h100);
    apb(0, 12'h000, 32'hc0);
    expq.push_back(16'h0008);
    expq.push_back(16'h0018);
    pulse(9'h009);
    wait_acc(5);
    quiet;
    apb(1, 12'h008, 32'h01);
    pulse(9'h100);
    wait_acc(6);
    chk("queue", 0, expq.size());
    results;
  end
endmodule // tlic_top_test
